// *** core/ovcal_pkg.sv ***
// Shared constants and carriers for current calibration and overvoltage limit registers.
package ovcal_pkg;
   // Command codes handled here.
   localparam logic [7:0] CMD_GAIN = 8'h38;
   localparam logic [7:0] CMD_OFFSET = 8'h39;
   localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
   // Phase selector that addresses the whole stack.
   localparam logic [7:0] PHASE_ALL = 8'hFF;
   localparam int MAX_PHASES = 4;
   // Linear word layout: exponent in bits 15:11, mantissa in 10:0.
   localparam int EXP_LSB = 11;
   localparam int MAN_W = 11;
   // Reset words: gain 128 * 2^-7 = 1.0, offset zero with exponent -4.
   localparam logic [15:0] GAIN_RESET = 16'hC880;
   localparam logic [15:0] OFFSET_RESET = 16'hE000;
   // Overvoltage limit reset, 1.25 in relative units of 2^-9.
   localparam logic [15:0] OV_LIMIT_RESET = 16'h0280;
   localparam logic [15:0] REL_UNITY = 16'h0200;
   // Exponents used when the block re-encodes a value.
   localparam logic [4:0] EXP_M4 = 5'h1C;
   localparam logic [4:0] EXP_M6 = 5'h1A;
   // Fixed point fractions for gain and offset.
   localparam int GAIN_FRAC = 10;
   localparam int OFF_FRAC = 4;
   localparam logic signed [23:0] GAIN_LIMIT_Q = 24'h000800;
   localparam logic signed [23:0] GAIN_HALF_STEP = 24'h000008;
   localparam logic signed [23:0] GAIN_NVM_MAX = 24'h00007F;
   localparam logic signed [23:0] OFF_MAX_Q = 24'h0000F0;
   localparam logic signed [23:0] OFF_HALF_STEP = 24'h000002;
   localparam int OFF_STEP_SH = 2;
   localparam logic signed [23:0] MAN_MAX = 24'h0003FF;
   // Threshold grid in tenths of a percent.
   localparam logic [11:0] PCT_SCALE = 12'h3E8;
   localparam logic [11:0] PCT_RUN_BASE = 12'h41A;
   localparam logic [11:0] PCT_RUN_STEP = 12'h019;
   localparam int PCT_RUN_CNT = 15;
   localparam logic [11:0] PCT_OFF_BASE = 12'h44C;
   localparam logic [11:0] PCT_OFF_STEP = 12'h064;
   localparam int PCT_OFF_CNT = 4;
   localparam logic [11:0] PCT_TOP = 12'h578;
   // Response field codes.
   localparam logic [1:0] OV_IGNORE = 2'h0;
   localparam logic [1:0] OV_INVALID = 2'h3;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Hiccup wait between restart attempts.
   localparam int CLK_MHZ = 20;
   localparam int HICCUP_US = 1000;
   localparam int HICCUP_CYC = HICCUP_US * CLK_MHZ;
   // One command from the bus front end.
   typedef struct packed {
      logic write;
      logic [7:0] code;
      logic [7:0] phase;
      logic [15:0] data;
   } cmd_req_t;
endpackage

// *** core/linear11_to_fixed.sv ***
// Decoder from signed linear word to signed fixed point.
`timescale 1ns/1ps
`default_nettype none
module linear11_to_fixed #(
   parameter int FRAC = 4
) (
   // Linear word in.
   input wire logic [15:0] word,
   // Fixed point out and range flag.
   output logic signed [23:0] value,
   output logic overflow
);
   // Shift the signed mantissa by exponent plus fraction width.
   always_comb begin
      int sh;
      logic signed [31:0] man32;
      sh = 0;
      man32 = 32'h00000000;
      sh = int'($signed(word[15:ovcal_pkg::EXP_LSB])) + FRAC;
      man32 = {{21{word[10]}}, word[10:0]};
      overflow = 1'b0;
      if (sh >= 0) begin
         // Beyond thirteen places the value no longer fits 24 bits.
         overflow = (sh > 13);
         man32 = man32 <<< sh;
      end else begin
         // Bits below the fraction are truncated toward minus infinity.
         man32 = man32 >>> (-sh);
      end
      value = man32[23:0];
   end
endmodule
`default_nettype wire

// *** core/ov_percent_map.sv ***
// Maps a voltage limit onto the supported percentage grid of the output target.
`timescale 1ns/1ps
`default_nettype none
module ov_percent_map (
   // Limit and the value that stands for 100 percent.
   input wire logic [15:0] limitVal,
   input wire logic [15:0] refVal,
   // High while conversion runs; selects the finer grid.
   input wire logic running,
   // Chosen percentage in tenths, and above-grid flag.
   output logic [11:0] pctTenths,
   output logic tooHigh
);
   // Scaled limit compared against each grid point.
   wire logic [31:0] lhs = 32'(limitVal) * 32'(ovcal_pkg::PCT_SCALE);
   wire logic [11:0] base = running ? ovcal_pkg::PCT_RUN_BASE : ovcal_pkg::PCT_OFF_BASE;
   wire logic [11:0] step = running ? ovcal_pkg::PCT_RUN_STEP : ovcal_pkg::PCT_OFF_STEP;
   // Number of grid points in use; a net must carry a four-state type, so this is a small vector.
   wire logic [4:0] cnt = running ? 5'(ovcal_pkg::PCT_RUN_CNT) : 5'(ovcal_pkg::PCT_OFF_CNT);
   // Walk the grid downward so the smallest point that covers the limit wins.
   always_comb begin
      logic [11:0] p;
      p = 12'h000;
      pctTenths = ovcal_pkg::PCT_TOP;
      tooHigh = 1'b1;
      for (int k = ovcal_pkg::PCT_RUN_CNT - 1; k >= 0; k--) begin
         p = base + 12'(k) * step;
         if (k < int'(cnt) && lhs <= 32'(refVal) * 32'(p)) begin
            pctTenths = p;
            tooHigh = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/current_cal_and_ov_limit_regs.sv ***
// Gain and offset trim registers, overvoltage limit and its fault response.
`timescale 1ns/1ps
`default_nettype none
module current_cal_and_ov_limit_regs #(
   parameter int NUM_PHASES_MAX = ovcal_pkg::MAX_PHASES,
   parameter int HICCUP_CYCLES = ovcal_pkg::HICCUP_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Command port from the bus front end.
   input wire logic cmdValid,
   input wire ovcal_pkg::cmd_req_t cmdReq,
   output logic [15:0] rdData,
   output logic rdValid,
   output logic invalidData,
   // Stack size and store or restore event.
   input wire logic [2:0] numPhases,
   input wire logic nvmEvent,
   // Current telemetry, signed with four fraction bits.
   input wire logic signed [15:0] sensedCurrent,
   output logic signed [15:0] reportedCurrent,
   output logic signed [15:0] stackOffset,
   // Overcurrent thresholds before and after gain scaling.
   input wire logic signed [15:0] ocFaultLimit,
   input wire logic signed [15:0] ocWarnLimit,
   output logic signed [15:0] ocFaultScaled,
   output logic signed [15:0] ocWarnScaled,
   // Output voltage target, mode, measurement and enable.
   input wire logic [15:0] voutCommand,
   input wire logic voutAbsMode,
   input wire logic [15:0] voutSensed,
   input wire logic convEnable,
   // Fault response setting.
   input wire logic [1:0] ovResponseCode,
   input wire logic [2:0] ovRetryCount,
   // Overvoltage status.
   output logic [11:0] ovHwPercent,
   output logic ovFaultEvent,
   output logic powerStageOn,
   output logic ovLatchedOff
);
   typedef enum logic [1:0] {OV_RUN, OV_HICCUP, OV_LATCH} ov_state_t;

   // Two-stage reset release; assertion is immediate.
   logic rstMeta_q;
   logic rstN;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN <= rstMeta_q;
      end
   end

   // Stored words.
   logic [15:0] gainWord_q;
   logic [15:0] offWord_q [NUM_PHASES_MAX];
   logic [15:0] ovLimit_q;

   // Decoded write data and stored values.
   logic signed [23:0] gainWrFix;
   logic signed [23:0] gainFix;
   logic signed [23:0] offWrFix;
   logic signed [23:0] offFix [NUM_PHASES_MAX];
   logic gainWrOvf;
   logic offWrOvf;

   linear11_to_fixed #(.FRAC(ovcal_pkg::GAIN_FRAC)) uGainWr (
      .word(cmdReq.data), .value(gainWrFix), .overflow(gainWrOvf));
   linear11_to_fixed #(.FRAC(ovcal_pkg::GAIN_FRAC)) uGain (
      .word(gainWord_q), .value(gainFix), .overflow());
   linear11_to_fixed #(.FRAC(ovcal_pkg::OFF_FRAC)) uOffWr (
      .word(cmdReq.data), .value(offWrFix), .overflow(offWrOvf));

   // One decoder per phase feeds the stack sum and restore rounding.
   for (genvar i = 0; i < NUM_PHASES_MAX; i++) begin : gOff
      linear11_to_fixed #(.FRAC(ovcal_pkg::OFF_FRAC)) uOff (
         .word(offWord_q[i]), .value(offFix[i]), .overflow());
   end

   // Re-encode an offset with exponent -4, saturating the mantissa.
   function automatic logic [15:0] encOff(input logic signed [23:0] q);
      logic signed [23:0] s;
      s = q;
      if (q > ovcal_pkg::MAN_MAX) s = ovcal_pkg::MAN_MAX;
      if (q < -ovcal_pkg::MAN_MAX) s = -ovcal_pkg::MAN_MAX;
      return {ovcal_pkg::EXP_M4, s[10:0]};
   endfunction

   // Command decode.
   wire logic isGain = cmdValid && cmdReq.code == ovcal_pkg::CMD_GAIN;
   wire logic isOff = cmdValid && cmdReq.code == ovcal_pkg::CMD_OFFSET;
   wire logic isOv = cmdValid && cmdReq.code == ovcal_pkg::CMD_OV_LIMIT;
   wire logic phaseAll = cmdReq.phase == ovcal_pkg::PHASE_ALL;
   wire logic phaseOne = cmdReq.phase < {5'h00, numPhases};
   wire logic [1:0] phIdx = cmdReq.phase[1:0];

   // Share of a stack total that each phase receives.
   logic signed [23:0] offShare;
   always_comb begin
      unique case (numPhases)
         3'h2: offShare = offWrFix >>> 1;
         3'h3: offShare = offWrFix / 24'sh000003;
         3'h4: offShare = offWrFix >>> 2;
         default: offShare = offWrFix;
      endcase
   end

   // Acceptance checks; a gain must stay above zero and below two.
   wire logic gainOk = !gainWrOvf && gainWrFix > 24'sh000000 &&
                       gainWrFix < ovcal_pkg::GAIN_LIMIT_Q;
   wire logic [23:0] offSel = phaseAll ? offShare : offWrFix;
   wire logic offInRange = $signed(offSel) <= ovcal_pkg::OFF_MAX_Q &&
                           $signed(offSel) >= -ovcal_pkg::OFF_MAX_Q;
   wire logic offOk = !offWrOvf && (phaseOne || phaseAll) && offInRange;
   wire logic offRdOk = phaseOne || phaseAll;

   // Overvoltage limit maps: one checks a write, one drives the hardware.
   wire logic [15:0] refVal = voutAbsMode ? voutCommand : ovcal_pkg::REL_UNITY;
   logic [11:0] wrPct;
   logic wrTooHigh;
   logic [11:0] hwPct;
   ov_percent_map uOvWr (.limitVal(cmdReq.data), .refVal(refVal),
      .running(1'b1), .pctTenths(wrPct), .tooHigh(wrTooHigh));
   ov_percent_map uOvHw (.limitVal(ovLimit_q), .refVal(refVal),
      .running(convEnable), .pctTenths(hwPct), .tooHigh());
   wire logic ovOk = !wrTooHigh;

   // Write and restore of the stored words; a write in the restore cycle wins.
   wire logic signed [23:0] gainRnd = (gainFix + ovcal_pkg::GAIN_HALF_STEP) >>> 4;
   wire logic signed [23:0] gainClamp = gainRnd > ovcal_pkg::GAIN_NVM_MAX ?
                                        ovcal_pkg::GAIN_NVM_MAX : gainRnd;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         gainWord_q <= ovcal_pkg::GAIN_RESET;
         ovLimit_q <= ovcal_pkg::OV_LIMIT_RESET;
         for (int i = 0; i < NUM_PHASES_MAX; i++) offWord_q[i] <= ovcal_pkg::OFFSET_RESET;
      end else begin
         if (nvmEvent) begin
            gainWord_q <= {ovcal_pkg::EXP_M6, gainClamp[10:0]};
            for (int i = 0; i < NUM_PHASES_MAX; i++)
               offWord_q[i] <= encOff(((offFix[i] + ovcal_pkg::OFF_HALF_STEP) >>>
                  ovcal_pkg::OFF_STEP_SH) <<< ovcal_pkg::OFF_STEP_SH);
         end
         if (isGain && cmdReq.write && gainOk) gainWord_q <= cmdReq.data;
         if (isOv && cmdReq.write && ovOk) ovLimit_q <= cmdReq.data;
         if (isOff && cmdReq.write && offOk) begin
            if (phaseAll) begin
               for (int i = 0; i < NUM_PHASES_MAX; i++) offWord_q[i] <= encOff(offShare);
            end else begin
               offWord_q[phIdx] <= cmdReq.data;
            end
         end
      end
   end

   // Read data and status answers, one cycle after the request.
   wire logic signed [23:0] p0Times = offFix[0] * $signed({21'h000000, numPhases});
   wire logic [15:0] offRd = phaseAll ? encOff(p0Times) : offWord_q[phIdx];
   wire logic rdBad = (isOff && !offRdOk);
   wire logic wrBad = cmdReq.write && ((isGain && !gainOk) || (isOff && !offOk) ||
                      (isOv && !ovOk));
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdData <= 16'h0000;
         rdValid <= 1'b0;
         invalidData <= 1'b0;
      end else begin
         rdValid <= (isGain || isOv || (isOff && offRdOk)) && !cmdReq.write;
         invalidData <= wrBad || (rdBad && !cmdReq.write);
         if (!cmdReq.write) begin
            if (isGain) rdData <= gainWord_q;
            if (isOff) rdData <= offRd;
            if (isOv) rdData <= ovLimit_q;
         end
      end
   end

   // Stack offset sum and calibrated telemetry.
   logic signed [23:0] offSum;
   always_comb begin
      offSum = 24'sh000000;
      for (int i = 0; i < NUM_PHASES_MAX; i++)
         if (i < int'(numPhases)) offSum = offSum + offFix[i];
   end
   wire logic signed [39:0] iProd = sensedCurrent * gainFix;
   wire logic signed [39:0] ocfProd = ocFaultLimit * gainFix;
   wire logic signed [39:0] ocwProd = ocWarnLimit * gainFix;
   wire logic signed [15:0] iCal = iProd[25:10] + offSum[15:0];
   // Registered so downstream compares see a settled value.
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         reportedCurrent <= 16'sh0000;
         stackOffset <= 16'sh0000;
         ocFaultScaled <= 16'sh0000;
         ocWarnScaled <= 16'sh0000;
         ovHwPercent <= ovcal_pkg::PCT_TOP;
      end else begin
         reportedCurrent <= iCal;
         stackOffset <= offSum[15:0];
         ocFaultScaled <= ocfProd[25:10];
         ocWarnScaled <= ocwProd[25:10];
         ovHwPercent <= hwPct;
      end
   end

   // Trip compare against the target, live from reset release.
   wire logic [31:0] vLhs = 32'(voutSensed) * 32'(ovcal_pkg::PCT_SCALE);
   wire logic [31:0] vRhs = 32'(voutCommand) * 32'(ovHwPercent);
   logic ovTrip_q;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ovTrip_q <= 1'b0;
         ovFaultEvent <= 1'b0;
      end else begin
         ovTrip_q <= vLhs > vRhs;
         ovFaultEvent <= (vLhs > vRhs) && !ovTrip_q;
      end
   end

   // Response machine; code 11b is not acted on since it cannot be stored.
   ov_state_t ovState_q;
   logic [31:0] hicCnt_q;
   logic [2:0] attempts_q;
   wire logic ovShut = ovTrip_q && ovResponseCode != ovcal_pkg::OV_IGNORE &&
                       ovResponseCode != ovcal_pkg::OV_INVALID;
   wire logic retryLeft = ovRetryCount == ovcal_pkg::RETRY_FOREVER ||
                          attempts_q < ovRetryCount;
   wire logic hicDone = hicCnt_q == 32'(HICCUP_CYCLES - 1);
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ovState_q <= OV_RUN;
         hicCnt_q <= 32'h00000000;
         attempts_q <= 3'h0;
      end else begin
         unique case (ovState_q)
            OV_RUN: begin
               if (ovShut && convEnable) begin
                  hicCnt_q <= 32'h00000000;
                  ovState_q <= retryLeft ? OV_HICCUP : OV_LATCH;
               end else if (hicDone) begin
                  // A clean hiccup period counts as a successful start.
                  attempts_q <= 3'h0;
               end else begin
                  hicCnt_q <= hicCnt_q + 32'h00000001;
               end
            end
            OV_HICCUP: begin
               if (hicDone) begin
                  hicCnt_q <= 32'h00000000;
                  ovState_q <= OV_RUN;
                  if (attempts_q != ovcal_pkg::RETRY_FOREVER) attempts_q <= attempts_q + 3'h1;
               end else begin
                  hicCnt_q <= hicCnt_q + 32'h00000001;
               end
            end
            OV_LATCH: begin
               // Only a command off releases the latch.
               if (!convEnable) begin
                  ovState_q <= OV_RUN;
                  attempts_q <= 3'h0;
                  hicCnt_q <= 32'h00000000;
               end
            end
         endcase
      end
   end
   assign powerStageOn = convEnable && ovState_q == OV_RUN;
   assign ovLatchedOff = ovState_q == OV_LATCH;

   // Checks next to the logic.
   sequence sEnterHiccup;
      ovState_q == OV_RUN ##1 ovState_q == OV_HICCUP;
   endsequence
   a_gain_write_takes: assert property (@(posedge clk) disable iff (!rstN)
      isGain && cmdReq.write && gainOk |=> gainWord_q == $past(cmdReq.data))
      else $error("gain write not stored");
   a_bad_gain_flag: assert property (@(posedge clk) disable iff (!rstN)
      isGain && cmdReq.write && !gainOk && !nvmEvent |=> invalidData && $stable(gainWord_q))
      else $error("bad gain not rejected");
   a_nvm_gain_round: assert property (@(posedge clk) disable iff (!rstN)
      nvmEvent && !(isGain && cmdReq.write) |=> gainWord_q[15:11] == ovcal_pkg::EXP_M6 &&
      $signed(gainWord_q[10:0]) <= 11'sh07F)
      else $error("gain not rounded on restore");
   a_phase_read: assert property (@(posedge clk) disable iff (!rstN)
      isOff && !cmdReq.write && phaseOne |=> rdValid && rdData == $past(offWord_q[phIdx]))
      else $error("phase read mismatch");
   a_all_write_split: assert property (@(posedge clk) disable iff (!rstN)
      isOff && cmdReq.write && offOk && phaseAll |=> offWord_q[0] == offWord_q[1] &&
      offWord_q[0] == encOff($past(offShare)))
      else $error("stack write not split");
   a_ov_shutdown: assert property (@(posedge clk) disable iff (!rstN)
      ovState_q == OV_RUN && ovShut && convEnable |=> !powerStageOn)
      else $error("no shutdown on fault");
   a_hiccup_wait: assert property (@(posedge clk) disable iff (!rstN)
      sEnterHiccup |-> (!powerStageOn)[*8])
      else $error("restart before hiccup");
   a_run_grid: assert property (@(posedge clk) disable iff (!rstN)
      convEnable && $stable(convEnable) |=> ovHwPercent >= ovcal_pkg::PCT_RUN_BASE &&
      ovHwPercent <= ovcal_pkg::PCT_TOP)
      else $error("percent off run grid");
   a_off_grid: assert property (@(posedge clk) disable iff (!rstN)
      !convEnable |=> ovHwPercent == 12'h44C || ovHwPercent == 12'h4B0 ||
      ovHwPercent == 12'h514 || ovHwPercent == 12'h578)
      else $error("percent off disabled grid");
   a_limit_kept: assert property (@(posedge clk) disable iff (!rstN)
      !isOv |=> $stable(ovLimit_q))
      else $error("limit moved without write");
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
// Command master standing in for the bus front end that feeds the register block.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock.
   input wire logic clk,
   // Requests towards the block.
   output logic cmdValid,
   output ovcal_pkg::cmd_req_t cmdReq,
   // Answers from the block.
   input wire logic [15:0] rdData,
   input wire logic rdValid,
   input wire logic invalidData
);
   // Idle from time zero so nothing is taken during reset.
   initial begin
      cmdValid = 1'b0;
      cmdReq = '0;
   end
   // One request per call, held for exactly one capturing edge.
   task automatic send(input ovcal_pkg::cmd_req_t req, output logic [15:0] data, output logic ok, output logic bad);
      @(negedge clk);
      cmdValid = 1'b1;
      cmdReq = req;
      @(negedge clk);
      cmdValid = 1'b0;
      // A released request bus shows the inverse, so a stale word can never pass as valid.
      cmdReq = ~req;
      // The answer pulses are registered on the capturing edge, so they are taken here, at the falling edge after it.
      data = rdData;
      ok = rdValid;
      bad = invalidData;
   endtask
endmodule
`default_nettype wire

// *** tb/test_current_cal_and_ov_limit_regs.sv ***
// Self-checking bench for the calibration and overvoltage limit registers.
`timescale 1ns/1ps
`default_nettype none
module test_current_cal_and_ov_limit_regs;
   // Short hiccup so retry scenarios stay brief.
   localparam int HIC = 16;
   logic clk, nrst, cmdValid, rdValid, invalidData, nvmEvent, voutAbsMode, convEnable;
   logic ovFaultEvent, powerStageOn, ovLatchedOff, okF, badF;
   logic [15:0] rdData, voutCommand, voutSensed, rd;
   logic signed [15:0] sensedCurrent, reportedCurrent, stackOffset, ocFaultLimit, ocWarnLimit;
   logic signed [15:0] ocFaultScaled, ocWarnScaled;
   logic [2:0] numPhases, ovRetryCount;
   logic [1:0] ovResponseCode;
   logic [11:0] ovHwPercent;
   ovcal_pkg::cmd_req_t cmdReq;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   // Limit word, conversion enable, expected grid point in tenths of a percent.
   int ovTab[6][3] = '{'{16'h0280, 1, 1250}, '{16'h0219, 1, 1050}, '{16'h0200, 1, 1050},
                       '{16'h02CC, 1, 1400}, '{16'h0280, 0, 1300}, '{16'h0234, 0, 1200}};

   current_cal_and_ov_limit_regs #(.NUM_PHASES_MAX(4), .HICCUP_CYCLES(HIC)) current_cal_and_ov_limit_regs_i (
      .clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdReq(cmdReq), .rdData(rdData), .rdValid(rdValid),
      .invalidData(invalidData), .numPhases(numPhases), .nvmEvent(nvmEvent), .sensedCurrent(sensedCurrent),
      .reportedCurrent(reportedCurrent), .stackOffset(stackOffset), .ocFaultLimit(ocFaultLimit),
      .ocWarnLimit(ocWarnLimit), .ocFaultScaled(ocFaultScaled), .ocWarnScaled(ocWarnScaled),
      .voutCommand(voutCommand), .voutAbsMode(voutAbsMode), .voutSensed(voutSensed), .convEnable(convEnable),
      .ovResponseCode(ovResponseCode), .ovRetryCount(ovRetryCount), .ovHwPercent(ovHwPercent),
      .ovFaultEvent(ovFaultEvent), .powerStageOn(powerStageOn), .ovLatchedOff(ovLatchedOff));
   host_model host_model_i (.clk(clk), .cmdValid(cmdValid), .cmdReq(cmdReq), .rdData(rdData),
      .rdValid(rdValid), .invalidData(invalidData));

   // Free running 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard well above the expected run length.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end

   // Prints counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Compares one observed word with its expectation.
   task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] gotv);
      n_tests++;
      if (gotv !== expv) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, expv, gotv);
      end
   endtask
   // One command through the host model; answers land in rd, okF and badF.
   task automatic acc(input logic wr, input logic [7:0] code, input logic [7:0] ph, input logic [15:0] d);
      host_model_i.send('{wr, code, ph, d}, rd, okF, badF);
   endtask
   // Waits a bounded time for a status output (0 event, 1 stage on, 2 latched) to go high.
   task automatic wait_on(input int sel, input int lim);
      for (int k = 0; k < lim; k++) begin
         if ((sel == 0 && ovFaultEvent === 1'b1) || (sel == 1 && powerStageOn === 1'b1) ||
             (sel == 2 && ovLatchedOff === 1'b1)) return;
         @(negedge clk);
      end
   endtask
   // Product of a value and a gain with ten fraction bits, plus an offset.
   function automatic logic [15:0] scale(input int s, input int g, input int o);
      return 16'(((s * g) >>> 10) + o);
   endfunction

   // Main sequence; all inputs change on the falling edge.
   initial begin
      int m;
      int s;
      int v;
      void'($urandom(32'h99B03CF3));
      {nrst, nvmEvent, voutAbsMode, convEnable, ovResponseCode, ovRetryCount} = '0;
      {sensedCurrent, ocFaultLimit, ocWarnLimit} = '0;
      numPhases = 3'h1;
      voutCommand = 16'h0200;
      voutSensed = 16'h0200;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      acc(0, 8'h38, 8'h00, 16'h0000); chk("gain reset", 16'hC880, rd);
      chk("read strobe", 16'h0001, {15'h0000, okF});
      acc(0, 8'h39, 8'h00, 16'h0000); chk("offset reset", 16'hE000, rd);
      acc(0, 8'h40, 8'h00, 16'h0000); chk("ov reset", 16'h0280, rd);
      $display("test reset done");
      // Random fine gains, then a store that snaps them; 255 exercises the upper clamp.
      for (int i = 0; i < 6; i++) begin
         m = (i == 5) ? 255 : 2 * $urandom_range(127, 32);
         s = $urandom_range(4000) - 2000;
         sensedCurrent = 16'(s);
         ocFaultLimit = 16'($urandom_range(1000));
         ocWarnLimit = 16'($urandom_range(1000));
         acc(1, 8'h38, 8'h00, {5'h19, 11'(m)}); chk("gain accepted", 16'h0000, {15'h0000, badF});
         acc(0, 8'h38, 8'h00, 16'h0000); chk("gain word", {5'h19, 11'(m)}, rd);
         repeat (3) @(negedge clk);
         chk("reported", scale(s, m * 8, 0), reportedCurrent);
         chk("fault scaled", scale(int'(ocFaultLimit), m * 8, 0), ocFaultScaled);
         chk("warn scaled", scale(int'(ocWarnLimit), m * 8, 0), ocWarnScaled);
         nvmEvent = 1'b1;
         @(negedge clk);
         nvmEvent = 1'b0;
         acc(0, 8'h38, 8'h00, 16'h0000); chk("gain stored", {5'h1A, 11'((m > 254) ? 127 : m / 2)}, rd);
      end
      acc(1, 8'h38, 8'h00, 16'h0000); chk("gain zero", 16'h0001, {15'h0000, badF});
      acc(1, 8'h38, 8'h00, 16'hC900); chk("gain two", 16'h0001, {15'h0000, badF});
      $display("test gain done");
      // Stack of two phases: split write, stack read as phase 0 times the phase count, and per-phase access.
      numPhases = 3'h2;
      acc(1, 8'h39, 8'hFF, 16'hE010);
      acc(0, 8'h39, 8'h01, 16'h0000); chk("phase split", 16'hE008, rd);
      acc(0, 8'h39, 8'hFF, 16'h0000); chk("stack read", 16'hE010, rd);
      chk("stack offset", 16'h0010, stackOffset);
      v = $urandom_range(480) - 240;
      acc(1, 8'h39, 8'h00, {5'h1C, 11'(v)});
      acc(0, 8'h39, 8'h00, 16'h0000); chk("fine offset", {5'h1C, 11'(v)}, rd);
      acc(0, 8'h39, 8'h01, 16'h0000); chk("other phase", 16'hE008, rd);
      chk("stack sum", 16'(v + 8), stackOffset);
      acc(1, 8'h39, 8'h03, 16'hE004); chk("absent phase", 16'h0001, {15'h0000, badF});
      acc(1, 8'h39, 8'h00, 16'hE190); chk("offset range", 16'h0001, {15'h0000, badF});
      // A store snaps the fine offset to the nearest quarter amp.
      nvmEvent = 1'b1;
      @(negedge clk);
      nvmEvent = 1'b0;
      acc(0, 8'h39, 8'h00, 16'h0000);
      chk("offset stored", {5'h1C, 11'(((v + 2) >>> 2) * 4)}, rd);
      $display("test offset done");
      // Threshold grid while running and while stopped.
      for (int i = 0; i < 6; i++) begin
         convEnable = ovTab[i][1][0];
         acc(1, 8'h40, 8'h00, 16'(ovTab[i][0]));
         repeat (3) @(negedge clk);
         chk("ov percent", 16'(ovTab[i][2]), {4'h0, ovHwPercent});
      end
      acc(1, 8'h40, 8'h00, 16'h02CE); chk("ov too high", 16'h0001, {15'h0000, badF});
      voutAbsMode = 1'b1;
      voutCommand = 16'h1000;
      acc(1, 8'h40, 8'h00, 16'h1400);
      voutCommand = 16'h2000;
      acc(0, 8'h40, 8'h00, 16'h0000); chk("abs limit kept", 16'h1400, rd);
      voutAbsMode = 1'b0;
      voutCommand = 16'h0200;
      acc(1, 8'h40, 8'h00, 16'h0280);
      $display("test threshold done");
      // Ignore response, then shutdown with one retry, then detection while stopped.
      convEnable = 1'b1;
      repeat (3) @(negedge clk);
      voutSensed = 16'd700;
      wait_on(0, 8); chk("ignored event", 16'h0001, {15'h0000, ovFaultEvent});
      chk("ignore keeps on", 16'h0001, {15'h0000, powerStageOn});
      voutSensed = 16'h0200;
      ovResponseCode = 2'h1;
      ovRetryCount = 3'h1;
      repeat (3) @(negedge clk);
      voutSensed = 16'd700;
      wait_on(0, 8); chk("fault event", 16'h0001, {15'h0000, ovFaultEvent});
      voutSensed = 16'h0200;
      repeat (2) @(negedge clk);
      chk("shut down", 16'h0000, {15'h0000, powerStageOn});
      wait_on(1, HIC + 8); chk("restart", 16'h0001, {15'h0000, powerStageOn});
      voutSensed = 16'd700;
      wait_on(2, 8); chk("latched", 16'h0001, {15'h0000, ovLatchedOff});
      voutSensed = 16'h0200;
      convEnable = 1'b0;
      repeat (4) @(negedge clk);
      chk("unlatched", 16'h0000, {15'h0000, ovLatchedOff});
      voutSensed = 16'd700;
      wait_on(0, 8); chk("armed stopped", 16'h0001, {15'h0000, ovFaultEvent});
      // Code 11b must not shut down; code 10b with no retries latches at once.
      voutSensed = 16'h0200;
      convEnable = 1'b1;
      ovResponseCode = 2'h3;
      repeat (3) @(negedge clk);
      voutSensed = 16'd700;
      repeat (3) @(negedge clk);
      chk("invalid code on", 16'h0001, {15'h0000, powerStageOn});
      ovResponseCode = 2'h2;
      ovRetryCount = 3'h0;
      repeat (3) @(negedge clk);
      chk("latch no retry", 16'h0001, {15'h0000, ovLatchedOff});
      $display("test fault done");
      close_out();
   end
endmodule
`default_nettype wire
